// File: logic/pnlpw_pkg.sv
`default_nettype none
package pnlpw_pkg;
   // -------------------------------------------------------------
   // register map of the host controller
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_SER = 8'h08;
   localparam int CTRL_PWR = 0;
   localparam int CTRL_METHOD = 1;
   localparam int CTRL_PULSE = 2;
   localparam int CTRL_MAP_LO = 3;
   localparam int CTRL_MAP_HI = 4;
   localparam int CTRL_CLEAR = 5;
   localparam int CTRL_W = 5;
   // straps left open after reset
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h18;
   localparam int SER_BUSY = 8;

   // -------------------------------------------------------------
   // sequence times in milliseconds
   // -------------------------------------------------------------
   localparam int LOGIC_SETTLE_MS = 1;
   localparam int SERIAL_WAIT_MS = 20;
   localparam int GUARD_MS = 1;
   localparam int INV_RISE_MAX_MS = 800;

   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_LOGIC = 3'h1,
      ST_LINK = 3'h2,
      ST_INV = 3'h3,
      ST_RUN = 3'h4,
      ST_BL_DOWN = 3'h5,
      ST_LINK_DOWN = 3'h6,
      ST_LOGIC_DOWN = 3'h7
   } pnlpw_state_e;

   typedef enum logic [1:0] {
      MAP_A = 2'h0,
      MAP_B = 2'h1,
      MAP_C = 2'h2
   } pnlpw_map_e;

   // least time rounds up; hz/1000 keeps the product in 32 bits
   function automatic int pnlpw_cycles(input int ms, input int hz);
      return ((hz + 999) / 1000) * ms;
   endfunction

   // strap pair (high, low) to input map; a low strap reads 0
   function automatic pnlpw_map_e pnlpw_map_decode(input logic hi,
                                                   input logic lo);
      case ({hi, lo})
         2'b10: return MAP_B;
         2'b01: return MAP_C;
         default: return MAP_A;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: logic/pnlpw_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pnlpw_if;
   // -------------------------------------------------------------
   // supplies and pixel link, driven by the host
   // -------------------------------------------------------------
   logic logic_supply;
   logic inv_supply;
   logic inv_rail_ok;
   logic [3:0] odd_lane;
   logic odd_link_clock;
   logic [3:0] even_lane;
   logic even_link_clock;
   // pins with output and active-low enable, except the two luminance inputs
   logic cs_o, cs_oe_n;
   logic sclk_o, sclk_oe_n;
   logic sdi_o, sdi_oe_n;
   logic bl_o, bl_oe_n;
   logic map_lo_o, map_lo_oe_n;
   logic map_hi_o, map_hi_oe_n;
   logic luminance_pulse_in;
   logic luminance_method_select;
   logic sdo_o, sdo_oe_n;

   // -------------------------------------------------------------
   // wire levels seen with the module's internal pulls
   // -------------------------------------------------------------
   wire cs_lvl = cs_oe_n ? 1'b1 : cs_o; // [R10]
   wire map_lo_lvl = map_lo_oe_n ? 1'b1 : map_lo_o; // [R10]
   wire map_hi_lvl = map_hi_oe_n ? 1'b1 : map_hi_o; // [R10]
   wire sclk_lvl = sclk_oe_n ? 1'b0 : sclk_o; // [R11]
   wire sdi_lvl = sdi_oe_n ? 1'b0 : sdi_o; // [R11]
   wire bl_lvl = bl_oe_n ? 1'b1 : bl_o; // open reads as on [R07]
   wire sdo_lvl = sdo_oe_n ? 1'b0 : sdo_o;

   modport host (
      output logic_supply, inv_supply, inv_rail_ok, odd_lane,
      output odd_link_clock, even_lane, even_link_clock,
      output cs_o, cs_oe_n, sclk_o, sclk_oe_n, sdi_o, sdi_oe_n,
      output bl_o, bl_oe_n, map_lo_o, map_lo_oe_n, map_hi_o,
      output map_hi_oe_n, luminance_pulse_in, luminance_method_select,
      input sdo_lvl
   );
   modport dev (
      input logic_supply, inv_supply, inv_rail_ok, odd_lane,
      input odd_link_clock, even_lane, even_link_clock,
      input cs_lvl, sclk_lvl, sdi_lvl, bl_lvl, map_lo_lvl, map_hi_lvl,
      input luminance_pulse_in, luminance_method_select,
      output sdo_o, sdo_oe_n
   );
endinterface
`default_nettype wire

// File: logic/pnlpw_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pnlpw_sync #(
   parameter int W = 1
) (
   input wire logic i_clk, // sampling clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic [W-1:0] i_d, // asynchronous inputs
   output logic [W-1:0] o_q // synchronised copy
);
   logic [W-1:0] meta_r;

   // -------------------------------------------------------------
   // two flip-flops; only the second stage is read outside
   // -------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_r <= '0;
         o_q <= '0;
      end
      else
      begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// File: logic/pnlpw_dev.sv
`timescale 1ns/1ns
`default_nettype none
module pnlpw_dev
   import pnlpw_pkg::*;
#(
   parameter int LINK_HZ = 20_833_334,
   parameter int RISE_MAX_CYC = pnlpw_cycles(INV_RISE_MAX_MS, LINK_HZ)
) (
   input wire logic i_link_clk, // module clock, link rate
   input wire logic i_arst_n, // async reset, active low
   pnlpw_if.dev pnl, // connector side
   output logic o_backlight_on, // lamps lit
   output logic o_prot_trip, // inverter protection latched
   output logic [1:0] o_map, // decoded input map
   output logic [3:0] o_odd_word, // last odd-port lane sample
   output logic [3:0] o_even_word, // last even-port lane sample
   output logic [7:0] o_table_byte // last serial byte received
);
   localparam int NS = 19;
   logic [NS-1:0] s;
   logic odd_ck_d_r, even_ck_d_r, sclk_d_r, prot_r;
   logic [31:0] rise_cnt_r;
   logic [7:0] sh_r;

   generate
      if (RISE_MAX_CYC < 1)
         $error("RISE_MAX_CYC must be at least one");
   endgenerate

   // every connector input is foreign to this clock
   pnlpw_sync #(.W(NS)) u_sync (
      .i_clk(i_link_clk),
      .i_arst_n(i_arst_n),
      .i_d({pnl.logic_supply, pnl.inv_supply, pnl.inv_rail_ok,
            pnl.bl_lvl, pnl.map_hi_lvl, pnl.map_lo_lvl, pnl.cs_lvl,
            pnl.sclk_lvl, pnl.sdi_lvl, pnl.odd_link_clock,
            pnl.odd_lane, pnl.even_link_clock, pnl.even_lane}),
      .o_q(s)
   );

   // ----
   // named views of the synchronised pins
   // ----
   wire vdd = s[18];
   wire inv_on = s[17];
   wire inv_ok = s[16];
   wire bl_req = s[15];
   wire cs_n = s[12];
   wire sclk = s[11];
   wire sdi = s[10];
   wire odd_ck = s[9];
   wire even_ck = s[4];
   wire odd_rise = odd_ck & ~odd_ck_d_r;
   wire even_rise = even_ck & ~even_ck_d_r;
   wire sclk_rise = sclk & ~sclk_d_r & ~cs_n & vdd;
   wire rise_late = inv_on & ~inv_ok &
      (rise_cnt_r >= 32'(RISE_MAX_CYC));

   // rise interval counter; trip holds until the supply is removed
   always_ff @(posedge i_link_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rise_cnt_r <= '0;
         prot_r <= 1'b0;
      end
      else
      begin
         rise_cnt_r <= (inv_on & ~inv_ok) ? rise_cnt_r + 32'h1 : '0;
         if (!inv_on)
            prot_r <= 1'b0;
         else if (rise_late)
            prot_r <= 1'b1; // [R06]
      end
   end

   // ----
   // lamps, strap map and link capture
   // ----
   always_ff @(posedge i_link_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_backlight_on <= 1'b0;
         o_prot_trip <= 1'b0;
         o_map <= MAP_A;
         odd_ck_d_r <= 1'b0;
         even_ck_d_r <= 1'b0;
         o_odd_word <= '0;
         o_even_word <= '0;
      end
      else
      begin
         o_backlight_on <= inv_ok & bl_req & ~prot_r & ~rise_late; // [R07] [R06]
         o_prot_trip <= prot_r;
         o_map <= pnlpw_map_decode(s[14], s[13]); // [R09]
         odd_ck_d_r <= odd_ck;
         even_ck_d_r <= even_ck;
         if (odd_rise & vdd)
            o_odd_word <= s[8:5]; // odd pixels on the first port [R12]
         if (even_rise & vdd)
            o_even_word <= s[3:0]; // even pixels on the second [R12]
      end
   end

   // serial table port: shift in on clock rise, echo last bit
   always_ff @(posedge i_link_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sclk_d_r <= 1'b0;
         sh_r <= '0;
         o_table_byte <= '0;
         pnl.sdo_o <= 1'b0;
         pnl.sdo_oe_n <= 1'b1;
      end
      else
      begin
         sclk_d_r <= sclk;
         pnl.sdo_oe_n <= cs_n | ~vdd; // [R13]
         if (sclk_rise)
         begin
            sh_r <= {sh_r[6:0], sdi};
            pnl.sdo_o <= sdi;
         end
         if (cs_n)
            o_table_byte <= sh_r;
      end
   end
endmodule
`default_nettype wire

// File: logic/pnlpw_host.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// [R01] link and serial pins idle outside valid
// [R02] serial access 20 ms after link start
// [R03] backlight only within link valid period
// [R04] logic supply removed after signals stop
// [R05] never cut single signals while operating
// [R06] inverter trips on rise beyond 800 ms
// [R07] backlight on when enable high or open
// [R08] luminance inputs only with inverter, backlight
// [R09] two straps pick one of three maps
// [R10] straps and chip select pulled up
// [R11] serial data and clock pulled down
// [R12] first port odd, second port even
// [R13] select, clock, data in; data out back
// [R14] logic, link, serial, backlight; reverse down
// [R15] delays in cycles, cleared synchronously
module pnlpw_host
   import pnlpw_pkg::*;
#(
   parameter int CLK_HZ = 125_000_000,
   parameter int LINK_DIV = 16,
   parameter int SCLK_DIV = 16,
   parameter int LOGIC_CYC = pnlpw_cycles(LOGIC_SETTLE_MS, CLK_HZ),
   parameter int SERIAL_CYC = pnlpw_cycles(SERIAL_WAIT_MS, CLK_HZ),
   parameter int GUARD_CYC = pnlpw_cycles(GUARD_MS, CLK_HZ)
) (
   input wire logic i_clk, // system clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic [7:0] i_addr, // register byte address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data, cycle after strobe
   input wire logic i_inv_rail_ok, // inverter rail reached level
   input wire logic [3:0] i_odd_px, // odd-pixel lane bits
   input wire logic [3:0] i_even_px, // even-pixel lane bits
   pnlpw_if.host pnl // panel connector
);
   localparam int HALF = LINK_DIV / 2;
   localparam int SHALF = SCLK_DIV / 2;
   pnlpw_state_e state_r, state_nxt;
   logic [CTRL_W-1:0] ctrl_r;
   logic clear_r;
   logic [31:0] cnt_r;
   logic [15:0] div_r, sdiv_r;
   logic pclk_r, rail_r, sdo_r;
   logic ser_busy_r, sclk_r;
   logic [4:0] half_r;
   logic [7:0] tx_r, rx_r;

   generate
      if (LINK_DIV < 2 || LINK_DIV % 2 != 0 || SCLK_DIV < 2 ||
          SCLK_DIV % 2 != 0 || GUARD_CYC < 1)
         $error("dividers must be even and at least two");
   endgenerate

   // rail monitor and returned serial data come from outside
   pnlpw_sync #(.W(2)) u_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_d({i_inv_rail_ok, pnl.sdo_lvl}),
      .o_q({rail_r, sdo_r})
   );

   // ----
   // sequence decode
   // ----
   wire pwr = ctrl_r[CTRL_PWR];
   wire cnt_done = cnt_r == 32'h0;
   wire link_on = state_r inside {ST_LINK, ST_INV, ST_RUN, ST_BL_DOWN};
   wire ser_ok = state_r inside {ST_INV, ST_RUN}; // [R02]
   wire bl_on = state_r == ST_RUN; // [R03]
   wire inv_on = state_r inside {ST_INV, ST_RUN, ST_BL_DOWN};
   wire vdd_on = state_r != ST_OFF;
   wire ser_go = i_wr & (i_addr == ADDR_SER) & ser_ok & ~ser_busy_r;
   wire sck_tick = ser_busy_r & (sdiv_r == 16'(SHALF - 1));
   wire pix_tick = div_r == 16'(HALF - 1);

   // power up in order, power down in reverse [R14]
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: if (pwr) state_nxt = ST_LOGIC;
         ST_LOGIC: if (!pwr) state_nxt = ST_LOGIC_DOWN;
            else if (cnt_done) state_nxt = ST_LINK;
         ST_LINK: if (!pwr) state_nxt = ST_BL_DOWN;
            else if (cnt_done) state_nxt = ST_INV;
         ST_INV: if (!pwr) state_nxt = ST_BL_DOWN;
            else if (rail_r) state_nxt = ST_RUN;
         ST_RUN: if (!pwr) state_nxt = ST_BL_DOWN;
         // the serial byte in flight is finished, though its pins float from here [R05]
         ST_BL_DOWN: if (cnt_done && !ser_busy_r)
            state_nxt = ST_LINK_DOWN;
         ST_LINK_DOWN: if (cnt_done) state_nxt = ST_LOGIC_DOWN;
         ST_LOGIC_DOWN: if (cnt_done) state_nxt = ST_OFF; // [R04]
         default: state_nxt = ST_OFF;
      endcase
   end

   // state and delay counter; the soft clear acts on the clock [R15]
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_r <= ST_OFF;
         cnt_r <= '0;
      end
      else if (clear_r)
      begin
         state_r <= ST_OFF;
         cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt != state_r)
            cnt_r <= state_nxt == ST_LOGIC ? 32'(LOGIC_CYC - 1) :
               state_nxt == ST_LINK ? 32'(SERIAL_CYC - 1) :
               32'(GUARD_CYC - 1); // [R15]
         else if (!cnt_done)
            cnt_r <= cnt_r - 32'h1;
      end
   end

   // ----
   // register port: writes, and read data one cycle later
   // ----
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctrl_r <= CTRL_RST;
         clear_r <= 1'b0;
         o_rdata <= '0;
      end
      else
      begin
         clear_r <= i_wr & (i_addr == ADDR_CTRL) & i_wdata[CTRL_CLEAR];
         if (i_wr && i_addr == ADDR_CTRL)
            ctrl_r <= i_wdata[CTRL_W-1:0];
         if (!i_rd)
            o_rdata <= '0;
         else if (i_addr == ADDR_CTRL)
            o_rdata <= {27'h0, ctrl_r};
         else if (i_addr == ADDR_STAT)
            o_rdata <= {25'h0, rail_r, ser_busy_r, ser_ok, link_on,
                        state_r};
         else if (i_addr == ADDR_SER)
            o_rdata <= {23'h0, ser_busy_r, rx_r};
         else
            o_rdata <= '0;
      end
   end

   // pixel clock by divider; lanes change on its falling edge and
   // sit low while the link is outside its valid period
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         div_r <= '0;
         pclk_r <= 1'b0;
         pnl.odd_lane <= '0;
         pnl.even_lane <= '0;
      end
      else
      begin
         div_r <= pix_tick ? '0 : div_r + 16'h1;
         if (pix_tick)
         begin
            pclk_r <= link_on & ~pclk_r; // [R01]
            if (pclk_r || !link_on)
            begin
               pnl.odd_lane <= link_on ? i_odd_px : '0; // [R12] [R01]
               pnl.even_lane <= link_on ? i_even_px : '0; // [R12]
            end
         end
      end
   end

   // ----
   // serial table engine: eight bits, msb first, sample on rise
   // a write while not allowed or busy is dropped [R02]
   // ----
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ser_busy_r <= 1'b0;
         sclk_r <= 1'b0;
         half_r <= '0;
         sdiv_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
      end
      else if (ser_go)
      begin
         ser_busy_r <= 1'b1;
         tx_r <= i_wdata[7:0];
         half_r <= '0;
         sdiv_r <= '0;
      end
      else if (ser_busy_r)
      begin
         sdiv_r <= sck_tick ? '0 : sdiv_r + 16'h1;
         if (sck_tick)
         begin
            sclk_r <= ~sclk_r;
            half_r <= half_r + 5'h1;
            if (!sclk_r)
               rx_r <= {rx_r[6:0], sdo_r}; // [R13]
            else
               tx_r <= {tx_r[6:0], 1'b0};
            if (half_r == 5'h0f)
               ser_busy_r <= 1'b0;
         end
      end
   end

   // ----
   // pin drive: supplies, serial lines, backlight, straps
   // ----
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pnl.logic_supply <= 1'b0;
         pnl.inv_supply <= 1'b0;
         pnl.inv_rail_ok <= 1'b0;
         pnl.odd_link_clock <= 1'b0;
         pnl.even_link_clock <= 1'b0;
         pnl.cs_o <= 1'b0;
         pnl.cs_oe_n <= 1'b1;
         pnl.sclk_o <= 1'b0;
         pnl.sclk_oe_n <= 1'b1;
         pnl.sdi_o <= 1'b0;
         pnl.sdi_oe_n <= 1'b1;
         pnl.bl_o <= 1'b0;
         pnl.bl_oe_n <= 1'b0;
         pnl.map_lo_o <= 1'b0;
         pnl.map_lo_oe_n <= 1'b1;
         pnl.map_hi_o <= 1'b0;
         pnl.map_hi_oe_n <= 1'b1;
         pnl.luminance_pulse_in <= 1'b0;
         pnl.luminance_method_select <= 1'b0;
      end
      else
      begin
         pnl.logic_supply <= vdd_on; // [R04]
         pnl.inv_supply <= inv_on;
         pnl.inv_rail_ok <= rail_r & inv_on;
         pnl.odd_link_clock <= pclk_r; // [R12]
         pnl.even_link_clock <= pclk_r; // [R12]
         // serial lines float outside the valid period [R01] [R13]
         pnl.cs_oe_n <= ~ser_ok;
         pnl.cs_o <= ~ser_busy_r;
         pnl.sclk_oe_n <= ~ser_ok;
         pnl.sclk_o <= sclk_r;
         pnl.sdi_oe_n <= ~ser_ok;
         pnl.sdi_o <= ser_busy_r & tx_r[7];
         // low drives the lamps off, release lets the pull win [R07]
         pnl.bl_o <= 1'b0;
         pnl.bl_oe_n <= bl_on; // [R03]
         // with the logic supply on, a strap bit of zero pulls the pin low; one, or no supply, leaves it open
         pnl.map_lo_oe_n <= ctrl_r[CTRL_MAP_LO] | ~vdd_on; // [R09]
         pnl.map_hi_oe_n <= ctrl_r[CTRL_MAP_HI] | ~vdd_on; // [R09]
         pnl.luminance_pulse_in <= bl_on & ctrl_r[CTRL_PULSE]; // [R08]
         pnl.luminance_method_select <= bl_on & ctrl_r[CTRL_METHOD]; // [R08]
      end
   end
endmodule
`default_nettype wire

// File: dv/pnlpw_props.sv
`timescale 1ns/1ns
`default_nettype none
module pnlpw_props #(
   parameter int SERIAL_CYC = 200,
   parameter int LINK_DIV = 16
) (
   input wire logic i_clk, // system clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic logic_supply, // panel logic rail
   input wire logic inv_supply, // inverter rail
   input wire logic [3:0] odd_lane, // odd port lanes
   input wire logic odd_link_clock, // odd port clock
   input wire logic [3:0] even_lane, // even port lanes
   input wire logic even_link_clock, // even port clock
   input wire logic cs_o, // chip select drive
   input wire logic cs_oe_n, // chip select enable, low drives
   input wire logic sclk_o, // serial clock drive
   input wire logic sclk_oe_n, // serial clock enable, low drives
   input wire logic sdi_o, // serial data drive
   input wire logic sdi_oe_n, // serial data enable, low drives
   input wire logic bl_lvl, // backlight enable level
   input wire logic luminance_pulse_in, // pulse level
   input wire logic luminance_method_select // method level
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   // ----
   // helper counters
   // ----
   int link_cnt;
   int stall;
   logic clk_q;
   // link age saturates so a long run cannot wrap back to zero
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         link_cnt <= 0;
         stall <= 0;
         clk_q <= 1'b0;
      end
      else
      begin
         if (!logic_supply)
            link_cnt <= 0;
         else if ((link_cnt != 0 || odd_link_clock) && link_cnt < 1000000)
            link_cnt <= link_cnt + 1;
         clk_q <= odd_link_clock;
         stall <= (clk_q != odd_link_clock) ? 0 : stall + 1;
      end
   end

   // ----
   // properties
   // ----
   property p_link_idle;
      !logic_supply |-> odd_lane == 4'h0 && even_lane == 4'h0 &&
         !odd_link_clock && !even_link_clock;
   endproperty
   a_link_idle: assert property (p_link_idle)
      else $error("link active without logic supply");
   property p_ser_idle;
      !logic_supply |-> (cs_oe_n || !cs_o) && (sclk_oe_n || !sclk_o) &&
         (sdi_oe_n || !sdi_o);
   endproperty
   a_ser_idle: assert property (p_ser_idle)
      else $error("serial line driven high without logic supply");
   // the first clock rise may come half a pixel period late
   property p_ser_wait;
      (!cs_oe_n || !sclk_oe_n || !sdi_oe_n) |->
         link_cnt >= SERIAL_CYC - LINK_DIV;
   endproperty
   a_ser_wait: assert property (p_ser_wait)
      else $error("serial access too soon after link start");
   property p_bl_valid;
      bl_lvl |-> link_cnt != 0 && inv_supply;
   endproperty
   a_bl_valid: assert property (p_bl_valid)
      else $error("backlight on outside link valid period");
   property p_logic_last;
      $fell(logic_supply) |->
         $past(!odd_link_clock && odd_lane == 4'h0 && !inv_supply && sdi_oe_n);
   endproperty
   a_logic_last: assert property (p_logic_last)
      else $error("logic supply removed with signals live");
   property p_link_runs;
      inv_supply && bl_lvl |-> stall <= LINK_DIV / 2;
   endproperty
   a_link_runs: assert property (p_link_runs)
      else $error("pixel clock stalled while lit");
   property p_lum_gate;
      luminance_pulse_in || luminance_method_select |-> inv_supply && bl_lvl;
   endproperty
   a_lum_gate: assert property (p_lum_gate)
      else $error("luminance input without inverter and backlight");
   property p_port_clk;
      odd_link_clock == even_link_clock;
   endproperty
   a_port_clk: assert property (p_port_clk)
      else $error("port clocks differ");
   property p_up_order;
      $rose(odd_link_clock) or $rose(inv_supply) |-> logic_supply;
   endproperty
   a_up_order: assert property (p_up_order)
      else $error("link or inverter before logic supply");
   property p_down_order;
      $fell(inv_supply) |-> logic_supply && !bl_lvl;
   endproperty
   a_down_order: assert property (p_down_order)
      else $error("inverter off out of order");
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import pnlpw_pkg::*;
   localparam int SER_CYC = 200;
   logic i_clk = 1'b0, i_arst_n = 1'b0, link_clk = 1'b0, dev_arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic wr = 1'b0, rd = 1'b0, rail_ok = 1'b0, bl_on, trip;
   logic [3:0] odd_px = 4'h0, even_px = 4'h0, odd_w, even_w;
   logic [1:0] map;
   logic [7:0] tbyte;
   int errors = 0, samples_checked = 0;
   pnlpw_map_e exp_map [4] = '{MAP_A, MAP_C, MAP_B, MAP_A};

   // ----
   // clocks, resets and instances
   // ----
   always #4 i_clk = ~i_clk;
   initial
   begin
      #5;
      forever #24 link_clk = ~link_clk;
   end
   // device leaves reset on its own edge, at the first link rise after host reset
   always @(posedge link_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         dev_arst_n <= 1'b0;
      else
         dev_arst_n <= 1'b1;
   end
   pnlpw_if pnl_if();
   pnlpw_host #(.LOGIC_CYC(20), .SERIAL_CYC(SER_CYC), .GUARD_CYC(10))
      u_pnlpw_host (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_inv_rail_ok(rail_ok), .i_odd_px(odd_px), .i_even_px(even_px),
      .pnl(pnl_if.host));
   pnlpw_dev #(.RISE_MAX_CYC(50)) u_pnlpw_dev (.i_link_clk(link_clk),
      .i_arst_n(dev_arst_n), .pnl(pnl_if.dev), .o_backlight_on(bl_on),
      .o_prot_trip(trip), .o_map(map), .o_odd_word(odd_w),
      .o_even_word(even_w), .o_table_byte(tbyte));
   pnlpw_props #(.SERIAL_CYC(SER_CYC), .LINK_DIV(16)) u_pnlpw_props (
      .i_clk(i_clk), .i_arst_n(i_arst_n),
      .logic_supply(pnl_if.logic_supply), .inv_supply(pnl_if.inv_supply),
      .odd_lane(pnl_if.odd_lane), .odd_link_clock(pnl_if.odd_link_clock),
      .even_lane(pnl_if.even_lane),
      .even_link_clock(pnl_if.even_link_clock), .cs_o(pnl_if.cs_o),
      .cs_oe_n(pnl_if.cs_oe_n), .sclk_o(pnl_if.sclk_o),
      .sclk_oe_n(pnl_if.sclk_oe_n), .sdi_o(pnl_if.sdi_o),
      .sdi_oe_n(pnl_if.sdi_oe_n), .bl_lvl(pnl_if.bl_lvl),
      .luminance_pulse_in(pnl_if.luminance_pulse_in),
      .luminance_method_select(pnl_if.luminance_method_select));

   // ----
   // bus and check tasks
   // ----
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_st(input pnlpw_state_e st);
      int n;
      n = 0;
      d = 32'hffff_ffff;
      while (d[2:0] !== st && n < 2000)
      begin
         rd_reg(ADDR_STAT, d);
         n++;
      end
      chk("state", 32'(d[2:0]), 32'(st));
   endtask
   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_reset;
      repeat (20) @(posedge i_clk);
      rd_reg(ADDR_CTRL, d);
      chk("ctrl reset", d, 32'(CTRL_RST));
      wr_reg(8'h0c, 32'hffff_ffff);
      rd_reg(8'h0c, d);
      chk("unmapped", d, 32'h0);
      chk("map open", 32'(map), 32'(MAP_A));
      chk("cs pull", 32'(pnl_if.cs_lvl), 32'h1);
      chk("sdi pull", 32'(pnl_if.sdi_lvl), 32'h0);
   endtask
   task automatic t_power_up;
      wr_reg(ADDR_CTRL, 32'h19);
      wait_st(ST_LINK);
      wr_reg(ADDR_SER, 32'h55);
      rd_reg(ADDR_SER, d);
      chk("early serial", 32'(d[SER_BUSY]), 32'h0);
      wait_st(ST_INV);
      chk("cs high", 32'(pnl_if.cs_lvl), 32'h1);
      rail_ok <= 1'b1;
      wait_st(ST_RUN);
      repeat (20) @(posedge i_clk);
      chk("lit", 32'(bl_on), 32'h1);
   endtask
   task automatic t_pixels;
      odd_px <= 4'h9;
      even_px <= 4'h6;
      repeat (60) @(posedge i_clk);
      chk("odd word", 32'(odd_w), 32'h9);
      chk("even word", 32'(even_w), 32'h6);
   endtask
   task automatic t_maps;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(ADDR_CTRL, 32'h07 | 32'(i) << 3);
         repeat (40) @(posedge i_clk);
         chk("map", 32'(map), 32'(exp_map[i]));
      end
      chk("pulse", 32'(pnl_if.luminance_pulse_in), 32'h1);
      wr_reg(ADDR_CTRL, 32'h19);
   endtask
   // second byte lands while busy and must be dropped
   task automatic t_serial;
      wr_reg(ADDR_SER, 32'ha5);
      wr_reg(ADDR_SER, 32'h3c);
      for (int n = 0; n < 200; n++)
      begin
         rd_reg(ADDR_SER, d);
         if (d[SER_BUSY] === 1'b0)
            break;
      end
      chk("busy end", 32'(d[SER_BUSY]), 32'h0);
      repeat (40) @(posedge i_clk);
      chk("table byte", 32'(tbyte), 32'ha5);
      chk("sclk idle", 32'(pnl_if.sclk_lvl), 32'h0);
   endtask
   task automatic t_power_down;
      wr_reg(ADDR_CTRL, 32'h18);
      wait_st(ST_OFF);
      rail_ok <= 1'b0;
      repeat (20) @(posedge i_clk);
      chk("dark", 32'(bl_on), 32'h0);
      chk("logic off", 32'(pnl_if.logic_supply), 32'h0);
      chk("sdi released", 32'(pnl_if.sdi_lvl), 32'h0);
   endtask
   // rail held low past the rise limit; later rail must not relight
   task automatic t_trip;
      wr_reg(ADDR_CTRL, 32'h19);
      wait_st(ST_INV);
      repeat (500) @(posedge i_clk);
      chk("trip", 32'(trip), 32'h1);
      rail_ok <= 1'b1;
      repeat (40) @(posedge i_clk);
      chk("trip dark", 32'(bl_on), 32'h0);
      t_power_down();
      chk("trip cleared", 32'(trip), 32'h0);
   endtask
   task automatic t_clear;
      wr_reg(ADDR_CTRL, 32'h19);
      repeat (4) @(posedge i_clk);
      wr_reg(ADDR_CTRL, 32'h38);
      rd_reg(ADDR_STAT, d);
      chk("clear state", 32'(d[2:0]), 32'(ST_OFF));
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge i_clk);
      i_arst_n <= 1'b1;
      t_reset();
      t_power_up();
      t_pixels();
      t_maps();
      t_serial();
      t_power_down();
      t_trip();
      t_clear();
      print_verdict();
   end
   initial
   begin
      repeat (30000) @(posedge i_clk);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
